//--- sct_defs.svh
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

// Log command opcodes and fixed task-file values
`define OP_SMART 8'hb0
`define OP_LOG_RD 8'h2f
`define OP_LOG_WR 8'h3f
`define SMART_LOG_RD 8'hd5
`define SMART_LOG_WR 8'hd6
`define SMART_KEY_LO 8'h4f
`define SMART_KEY_HI 8'hc2
`define PAGE_STATUS 8'he0
`define PAGE_DATA 8'he1
`define MAX_SECTORS 8'h08

// Status response contents
`define FMT_VERSION 16'h0003
`define SPEC_LEVEL 16'h0001
`define IMPL_VERSION 16'h0100
`define EXT_OK 16'h0000
`define EXT_NO_CMD 16'h000b
`define EXT_RUNNING 16'hffff
`define BY_FMT 9'h000
`define BY_IMPL 9'h002
`define BY_SPEC 9'h004
`define BY_FLAGS 9'h006
`define BY_STATE 9'h00a
`define BY_EXT 9'h00e
`define BY_ACTION 9'h010
`define BY_FUNC 9'h012

// Controller register offsets and fields
`define REG_CTRL 12'h000
`define REG_TF_A 12'h004
`define REG_TF_B 12'h008
`define REG_STAT 12'h00c
`define BUF_BASE 12'h200
`define CTRL_GO 0
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2

`endif

//--- sct_pkg.sv
`default_nettype none
package sct_pkg;
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_SEND = 3'b010,
        D_RECV = 3'b100
    } dev_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_ISSUE = 3'b010,
        H_WAIT = 3'b100
    } host_state_e;
endpackage
`default_nettype wire

//--- sct_link_if.sv
`default_nettype none
interface sct_link_if;
    // Task file, one-cycle command strobe
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [7:0] cmd_feat;
    logic [15:0] cmd_count;
    logic [7:0] lba_lo;
    logic [15:0] lba_mid;
    logic [7:0] lba_hi;
    // Command completion
    logic busy;
    logic done;
    logic err;
    // Device-to-host bytes
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_last;
    // Host-to-device bytes
    logic wr_valid;
    logic [7:0] wr_data;
    logic wr_ready;

    modport dev (
        input cmd_valid, cmd_op, cmd_feat, cmd_count, lba_lo, lba_mid, lba_hi, wr_valid, wr_data,
        output busy, done, err, rd_valid, rd_data, rd_last, wr_ready
    );
    modport host (
        output cmd_valid, cmd_op, cmd_feat, cmd_count, lba_lo, lba_mid, lba_hi, wr_valid, wr_data,
        input busy, done, err, rd_valid, rd_data, rd_last, wr_ready
    );
endinterface
`default_nettype wire

//--- sct_log_status_responder.sv
// Contract
// - Log ext 2Fh/3Fh with page E1h accepted
// - Completion reports only acceptance or error
// - Page E0h holds and returns status
// - Status read served anytime, even busy
// - Status read disturbs no power or activity
// - Host polls status for long actions
// - SMART B0h/C2h/4Fh, count one, page E0h
// - Log ext 2Fh, E0h, mid 00h, count one
// - Bytes 1:0 carry format version 0003h
// - Bytes 5:4 carry spec level 0001h
// - Bytes 3:2 carry implementation version
// - Flag bit0 set after full write-same
// - Any user LBA write clears flag
// - Capacity change also clears flag
// - Flag survives power cycles
// - Byte 10 encodes drive state 0..5
// - Bytes 15:14 last code, FFFFh while running
// - Code 0000h means completed without error
// - Data transfer without command gives 000Bh
`include "sct_defs.svh"
`default_nettype none
module sct_log_status_responder
    import sct_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Host link
    sct_link_if.dev link,
    // Drive condition from the rest of the controller
    input wire logic [7:0] drive_state,
    input wire logic user_lba_write,
    input wire logic capacity_change,
    input wire logic write_same_all_ok,
    input wire logic nv_seg_init,
    // Action engine hand-off
    input wire logic sct_busy,
    input wire logic sct_done,
    input wire logic [15:0] sct_done_code,
    input wire logic [7:0] sct_rd_byte,
    output logic sct_cmd_valid,
    output logic [15:0] sct_action,
    output logic [15:0] sct_function,
    output logic sct_wr_valid,
    output logic [7:0] sct_wr_byte,
    output logic [12:0] sct_idx,
    // Flag copy for the non-volatile store
    output logic seg_init
);

    typedef struct packed {
        dev_state_e st;
        logic busy;
        logic done;
        logic err;
        logic rd_valid;
        logic rd_last;
        logic [7:0] rd_data;
        logic wr_ready;
        logic [12:0] cnt;
        logic [12:0] total;
        logic data_page;
        logic cmd_issued;
        logic [15:0] last_code;
        logic [15:0] action;
        logic [15:0] func;
        logic seg;
        logic loaded;
        logic sct_cmd_valid;
        logic sct_wr_valid;
        logic [7:0] sct_wr_byte;
    } dev_s;

    dev_s r;
    dev_s next_r;

    // Status page byte at a given offset; unlisted bytes stay zero
    function automatic logic [7:0] status_byte(input logic [8:0] idx, input logic [15:0] ext,
                                               input logic [15:0] act, input logic [15:0] fn,
                                               input logic seg_f, input logic [7:0] dstate);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            `BY_FMT: b = 8'(`FMT_VERSION);
            `BY_FMT + 9'h001: b = 8'(`FMT_VERSION >> 8);
            `BY_IMPL: b = 8'(`IMPL_VERSION);
            `BY_IMPL + 9'h001: b = 8'(`IMPL_VERSION >> 8);
            `BY_SPEC: b = 8'(`SPEC_LEVEL);
            `BY_SPEC + 9'h001: b = 8'(`SPEC_LEVEL >> 8);
            `BY_FLAGS: b = {7'h00, seg_f};
            `BY_STATE: b = dstate;
            `BY_EXT: b = ext[7:0];
            `BY_EXT + 9'h001: b = ext[15:8];
            `BY_ACTION: b = act[7:0];
            `BY_ACTION + 9'h001: b = act[15:8];
            `BY_FUNC: b = fn[7:0];
            `BY_FUNC + 9'h001: b = fn[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Decoded request, valid while a command strobe is present
    logic smart_form;
    logic ext_form;
    logic is_write;
    logic [7:0] nsec;
    logic count_ok;
    logic form_ok;
    logic [15:0] ext_code;
    logic wr_hs;
    logic [12:0] cnt_inc;
    logic [7:0] send_byte;

    always_comb begin
        nsec = link.cmd_count[7:0];
        smart_form = link.cmd_op == `OP_SMART && link.lba_hi == `SMART_KEY_HI
            && link.lba_mid[7:0] == `SMART_KEY_LO
            && (link.cmd_feat == `SMART_LOG_RD || link.cmd_feat == `SMART_LOG_WR);
        ext_form = (link.cmd_op == `OP_LOG_RD || link.cmd_op == `OP_LOG_WR)
            && link.lba_mid == 16'h0000 && link.cmd_count[15:8] == 8'h00;
        is_write = smart_form ? link.cmd_feat == `SMART_LOG_WR : link.cmd_op == `OP_LOG_WR;
        if (link.lba_lo == `PAGE_STATUS) begin
            count_ok = nsec == 8'h01;
        end else if (smart_form) begin
            count_ok = nsec != 8'h00 && nsec <= `MAX_SECTORS;
        end else begin
            count_ok = nsec == 8'h01 || nsec == `MAX_SECTORS;
        end
        form_ok = (smart_form || ext_form) && count_ok
            && (link.lba_lo == `PAGE_STATUS || link.lba_lo == `PAGE_DATA);
        ext_code = sct_busy ? `EXT_RUNNING : r.last_code;
        wr_hs = link.wr_valid && r.wr_ready;
        cnt_inc = r.cnt + 13'h0001;
        send_byte = r.data_page ? sct_rd_byte
            : status_byte(r.cnt[8:0], ext_code, r.action, r.func, r.seg, drive_state);
    end

    // Next-state logic; the status page is built from live state only, so reading it
    // never touches the power state or the action engine
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.rd_valid = 1'b0;
        next_r.rd_last = 1'b0;
        next_r.sct_cmd_valid = 1'b0;
        next_r.sct_wr_valid = 1'b0;
        next_r.loaded = 1'b1;
        // Flag restored once after reset, then maintained
        if (!r.loaded) begin
            next_r.seg = nv_seg_init;
        end else if (user_lba_write || capacity_change) begin
            next_r.seg = 1'b0;
        end else if (write_same_all_ok) begin
            next_r.seg = 1'b1;
        end
        // Completion code from the action engine
        if (sct_done) begin
            next_r.last_code = sct_done_code;
        end
        case (r.st)
            D_IDLE: begin
                if (link.cmd_valid) begin
                    if (!form_ok) begin
                        next_r.done = 1'b1;
                        next_r.err = 1'b1;
                    end else if (link.lba_lo == `PAGE_DATA && !r.cmd_issued) begin
                        next_r.done = 1'b1;
                        next_r.err = 1'b1;
                        next_r.last_code = `EXT_NO_CMD;
                    end else begin
                        next_r.busy = 1'b1;
                        next_r.err = 1'b0;
                        next_r.cnt = 13'h0000;
                        next_r.total = {nsec[3:0], 9'h000};
                        next_r.data_page = link.lba_lo == `PAGE_DATA;
                        next_r.wr_ready = is_write;
                        next_r.st = is_write ? D_RECV : D_SEND;
                    end
                end
            end
            D_SEND: begin
                next_r.rd_valid = 1'b1;
                next_r.rd_data = send_byte;
                next_r.cnt = cnt_inc;
                if (cnt_inc == r.total) begin
                    next_r.rd_last = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st = D_IDLE;
                end
            end
            D_RECV: begin
                if (wr_hs) begin
                    next_r.cnt = cnt_inc;
                    if (r.data_page) begin
                        next_r.sct_wr_valid = 1'b1;
                        next_r.sct_wr_byte = link.wr_data;
                    end else begin
                        // Key sector: action code then function code
                        case (r.cnt)
                            13'h0000: next_r.action[7:0] = link.wr_data;
                            13'h0001: next_r.action[15:8] = link.wr_data;
                            13'h0002: next_r.func[7:0] = link.wr_data;
                            13'h0003: next_r.func[15:8] = link.wr_data;
                            default: ;
                        endcase
                    end
                    if (cnt_inc == r.total) begin
                        next_r.wr_ready = 1'b0;
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                        next_r.st = D_IDLE;
                        if (!r.data_page) begin
                            next_r.sct_cmd_valid = 1'b1;
                            next_r.cmd_issued = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_r.st = D_IDLE;
                next_r.busy = 1'b0;
                next_r.wr_ready = 1'b0;
            end
        endcase
    end

    // State register; the flag reloads from the store after every reset
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= D_IDLE;
            r.last_code <= `EXT_OK;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign link.busy = r.busy;
    assign link.done = r.done;
    assign link.err = r.err;
    assign link.rd_valid = r.rd_valid;
    assign link.rd_data = r.rd_data;
    assign link.rd_last = r.rd_last;
    assign link.wr_ready = r.wr_ready;
    assign sct_cmd_valid = r.sct_cmd_valid;
    assign sct_action = r.action;
    assign sct_function = r.func;
    assign sct_wr_valid = r.sct_wr_valid;
    assign sct_wr_byte = r.sct_wr_byte;
    assign sct_idx = r.cnt;
    assign seg_init = r.seg;

endmodule
`default_nettype wire

//--- sct_log_host.sv
`include "sct_defs.svh"
`default_nettype none
module sct_log_host
    import sct_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the drive
    sct_link_if.host link
);

    typedef struct packed {
        host_state_e st;
        logic [127:0][31:0] buf_w;
        logic [31:0] tf_a;
        logic [31:0] tf_b;
        logic busy;
        logic done;
        logic err;
        logic [8:0] ridx;
        logic [8:0] widx;
        logic cmd_valid;
        logic wr_valid;
        logic [7:0] wr_data;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } host_s;

    host_s r;
    host_s next_r;

    // Byte of the sector buffer, little-endian within each word
    function automatic logic [7:0] buf_byte(input logic [127:0][31:0] b, input logic [8:0] idx);
        return 8'(b[idx[8:2]] >> {idx[1:0], 3'b000});
    endfunction

    logic setup;
    logic in_buf;
    logic mapped;
    logic wr_hs;
    logic is_write;
    logic [8:0] widx_n;

    always_comb begin
        setup = psel && !penable && !r.pready;
        in_buf = paddr >= `BUF_BASE;
        mapped = in_buf || paddr == `REG_CTRL || paddr == `REG_TF_A
            || paddr == `REG_TF_B || paddr == `REG_STAT;
        wr_hs = r.wr_valid && link.wr_ready;
        is_write = r.tf_a[7:0] == `OP_SMART ? r.tf_a[15:8] == `SMART_LOG_WR : r.tf_a[7:0] == `OP_LOG_WR;
        widx_n = r.widx + {8'h00, wr_hs};
    end

    // No wait state: the answer is prepared in the setup cycle
    always_comb begin
        next_r = r;
        next_r.cmd_valid = 1'b0;
        next_r.pready = setup;
        next_r.pslverr = setup && (!mapped || paddr[1:0] != 2'b00);
        if (setup && mapped) begin
            if (in_buf) begin
                next_r.prdata = r.buf_w[paddr[8:2]];
            end else begin
                case (paddr)
                    `REG_TF_A: next_r.prdata = r.tf_a;
                    `REG_TF_B: next_r.prdata = r.tf_b;
                    `REG_STAT: next_r.prdata = {29'h0, r.err, r.done, r.busy};
                    default: next_r.prdata = {31'h0, r.busy};
                endcase
            end
        end
        // Writes take effect at the completing edge; registers frozen while busy
        if (psel && penable && r.pready && pwrite && !r.pslverr && !r.busy) begin
            if (in_buf) begin
                next_r.buf_w[paddr[8:2]] = pwdata;
            end else begin
                case (paddr)
                    `REG_TF_A: next_r.tf_a = pwdata;
                    `REG_TF_B: next_r.tf_b = pwdata;
                    `REG_STAT: next_r.done = r.done && !pwdata[`STAT_DONE];
                    default: begin
                        if (pwdata[`CTRL_GO]) begin
                            next_r.busy = 1'b1;
                            next_r.done = 1'b0;
                            next_r.st = H_ISSUE;
                        end
                    end
                endcase
            end
        end
        case (r.st)
            H_IDLE: begin
                next_r.wr_valid = 1'b0;
            end
            H_ISSUE: begin
                next_r.cmd_valid = 1'b1;
                next_r.ridx = 9'h000;
                next_r.widx = 9'h000;
                next_r.wr_valid = is_write;
                next_r.wr_data = buf_byte(r.buf_w, 9'h000);
                next_r.st = H_WAIT;
            end
            H_WAIT: begin
                if (link.rd_valid) begin
                    next_r.buf_w[r.ridx[8:2]][r.ridx[1:0] * 8 +: 8] = link.rd_data;
                    next_r.ridx = r.ridx + 9'h001;
                end
                next_r.widx = widx_n;
                next_r.wr_data = buf_byte(r.buf_w, widx_n);
                if (link.done) begin
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.err = link.err;
                    next_r.wr_valid = 1'b0;
                    next_r.st = H_IDLE;
                end
            end
            default: next_r.st = H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= H_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.cmd_valid = r.cmd_valid;
    assign link.cmd_op = r.tf_a[7:0];
    assign link.cmd_feat = r.tf_a[15:8];
    assign link.cmd_count = r.tf_a[31:16];
    assign link.lba_lo = r.tf_b[7:0];
    assign link.lba_mid = r.tf_b[23:8];
    assign link.lba_hi = r.tf_b[31:24];
    assign link.wr_valid = r.wr_valid;
    assign link.wr_data = r.wr_data;

endmodule
`default_nettype wire

//--- sct_link_assertions.sv
`include "sct_defs.svh"
`default_nettype none
module sct_link_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Task file from the host end
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_feat,
    input wire logic [15:0] cmd_count,
    input wire logic [7:0] lba_lo,
    input wire logic [15:0] lba_mid,
    input wire logic [7:0] lba_hi,
    // Completion and byte streams
    input wire logic busy,
    input wire logic done,
    input wire logic err,
    input wire logic rd_valid,
    input wire logic rd_last
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    logic [15:0] nbytes;
    logic [7:0] nsec;
    logic taken;
    logic ext_stat;
    logic smart_stat;
    logic bad_op;

    // Command forms decoded from the task file
    assign taken = cmd_valid && !busy;
    assign ext_stat = cmd_op == `OP_LOG_RD && lba_lo == `PAGE_STATUS && lba_mid == 16'h0000 && cmd_count == 16'h0001;
    assign smart_stat = cmd_op == `OP_SMART && cmd_feat == `SMART_LOG_RD && lba_mid[7:0] == `SMART_KEY_LO
        && lba_hi == `SMART_KEY_HI && cmd_count[7:0] == 8'h01 && lba_lo == `PAGE_STATUS;
    assign bad_op = !(cmd_op inside {`OP_SMART, `OP_LOG_RD, `OP_LOG_WR});

    // Bytes sent since the last taken command; sector count latched with it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            nbytes <= 16'h0000;
            nsec <= 8'h00;
        end else if (taken) begin
            nbytes <= 16'h0000;
            nsec <= cmd_count[7:0];
        end else if (rd_valid) begin
            nbytes <= nbytes + 16'h0001;
        end
    end

    a_reject_bad_op: assert property (
        taken && bad_op |=> done && err) else $error("unknown opcode not rejected");
    a_ext_status_served: assert property (
        taken && ext_stat |-> ##[1:3] (rd_valid && !err)) else $error("ext status not served");
    a_smart_status_served: assert property (
        taken && smart_stat |-> ##[1:3] (rd_valid && !err)) else $error("smart status not served");
    a_done_one_pulse: assert property (
        done |=> !done) else $error("done longer than one cycle");
    a_last_with_done: assert property (
        rd_last |-> done && rd_valid) else $error("last byte without done");
    a_sector_length: assert property (
        rd_last |-> (nbytes + 16'h0001) == {nsec[6:0], 9'h000}) else $error("read not whole sectors");
    a_err_cleared: assert property (
        $fell(err) |-> $past(cmd_valid) || $past(cmd_valid, 2)) else $error("err fell with no command");
    a_accept_had_busy: assert property (
        done && !err |-> $past(busy)) else $error("accept without transfer");
endmodule
`default_nettype wire

//--- tb_top.sv
`include "sct_defs.svh"
`default_nettype none
module tb_top import sct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] impl_ver = `IMPL_VERSION;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] drive_state = 8'h00;
    logic user_lba_write = 1'b0;
    logic capacity_change = 1'b0;
    logic write_same_all_ok = 1'b0;
    logic nv_seg_init = 1'b1;
    logic sct_busy = 1'b0;
    logic sct_done = 1'b0;
    logic [15:0] sct_done_code = 16'h0000;
    logic [7:0] sct_rd_byte;
    logic sct_cmd_valid;
    logic [15:0] sct_action;
    logic [15:0] sct_function;
    logic sct_wr_valid;
    logic [7:0] sct_wr_byte;
    logic [12:0] sct_idx;
    logic seg_init;
    logic exp_seg = 1'b1;
    logic [15:0] exp_ext = 16'h0000;
    logic [15:0] exp_act = 16'h0000, exp_fn = 16'h0000;
    logic [15:0] got_act, got_fn;
    logic [31:0] rng = 32'd71;
    int fail_count = 0;
    int tests_run = 0;
    int cmd_seen = 0;
    int wr_seen = 0;

    sct_link_if sct_link_if_inst ();
    sct_log_status_responder sct_log_status_responder_inst (.mclk, .rst_b, .link(sct_link_if_inst), .drive_state,
        .user_lba_write, .capacity_change, .write_same_all_ok, .nv_seg_init, .sct_busy, .sct_done, .sct_done_code,
        .sct_rd_byte, .sct_cmd_valid, .sct_action, .sct_function, .sct_wr_valid, .sct_wr_byte, .sct_idx, .seg_init);
    sct_log_host sct_log_host_inst (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link(sct_link_if_inst));
    sct_link_assertions sct_link_assertions_inst (.mclk, .rst_b, .cmd_valid(sct_link_if_inst.cmd_valid),
        .cmd_op(sct_link_if_inst.cmd_op), .cmd_feat(sct_link_if_inst.cmd_feat),
        .cmd_count(sct_link_if_inst.cmd_count), .lba_lo(sct_link_if_inst.lba_lo),
        .lba_mid(sct_link_if_inst.lba_mid), .lba_hi(sct_link_if_inst.lba_hi), .busy(sct_link_if_inst.busy),
        .done(sct_link_if_inst.done), .err(sct_link_if_inst.err), .rd_valid(sct_link_if_inst.rd_valid),
        .rd_last(sct_link_if_inst.rd_last));

    // Engine bytes tied to the index, so stale ones show
    assign sct_rd_byte = sct_idx[7:0] ^ 8'h5a;

    always #50 mclk = ~mclk;

    // Count hand-offs to the action engine
    always @(posedge mclk) begin
        if (sct_cmd_valid === 1'b1) begin
            cmd_seen++;
            got_act = sct_action;
            got_fn = sct_function;
        end
        if (sct_wr_valid === 1'b1) wr_seen++;
    end

    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Expected status page byte
    function automatic logic [7:0] eb(input int n);
        case (n)
            0: eb = 8'h03;
            2: eb = impl_ver[7:0];
            3: eb = impl_ver[15:8];
            4: eb = 8'h01;
            6: eb = {7'h00, exp_seg};
            10: eb = drive_state;
            14: eb = exp_ext[7:0];
            15: eb = exp_ext[15:8];
            16: eb = exp_act[7:0];
            17: eb = exp_act[15:8];
            18: eb = exp_fn[7:0];
            19: eb = exp_fn[15:8];
            default: eb = 8'h00;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One APB transfer; waits for pready, up to 50 cycles
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            wrap_up();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_cmd(input logic [31:0] ta, input logic [31:0] tb, output logic e);
        logic [31:0] q;
        int n;
        apb(1'b1, `REG_TF_A, ta, q);
        apb(1'b1, `REG_TF_B, tb, q);
        apb(1'b1, `REG_CTRL, 32'h1, q);
        n = 0;
        do begin
            apb(1'b0, `REG_STAT, 32'h0, q);
            n++;
        end while (q[`STAT_DONE] !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            fail_count++;
            wrap_up();
        end
        e = q[`STAT_ERR];
        apb(1'b1, `REG_STAT, 32'h2, q);
    endtask

    // Status page by either path, all 512 bytes compared
    task automatic status(input logic smart);
        logic e;
        logic [31:0] q;
        if (smart) run_cmd({16'h0001, `SMART_LOG_RD, `OP_SMART}, {`SMART_KEY_HI, 8'h00, `SMART_KEY_LO, `PAGE_STATUS}, e);
        else run_cmd({16'h0001, 8'h00, `OP_LOG_RD}, {8'h00, 16'h0000, `PAGE_STATUS}, e);
        check("status_err", e, 32'h0);
        for (int k = 0; k < 128; k++) begin
            apb(1'b0, `BUF_BASE + 12'(4 * k), 32'h0, q);
            check("status_word", q, {eb(4 * k + 3), eb(4 * k + 2), eb(4 * k + 1), eb(4 * k)});
        end
        check("no_action_started", cmd_seen, 32'(exp_act != 16'h0000));
    endtask

    // Flag events for one cycle, then the stored flag
    task automatic flag_step(input logic [2:0] v, input logic e);
        @(posedge mclk);
        {user_lba_write, capacity_change, write_same_all_ok} <= v;
        @(posedge mclk);
        {user_lba_write, capacity_change, write_same_all_ok} <= 3'b000;
        repeat (2) @(posedge mclk);
        check("seg_init", seg_init, 32'(e));
        exp_seg = e;
    endtask

    task automatic engine_done();
        @(posedge mclk);
        sct_done <= 1'b1;
        @(posedge mclk);
        sct_done <= 1'b0;
        exp_ext = 16'h0000;
    endtask

    initial begin
        logic e;
        logic [31:0] q;
        logic [31:0] key;
        int k;
        logic [63:0] bad [4];
        bad[0] = {8'h00, 16'h0000, `PAGE_STATUS, 16'h0001, 8'h00, 8'h55};
        bad[1] = {8'h00, 16'h0000, 8'he2, 16'h0001, 8'h00, `OP_LOG_RD};
        bad[2] = {8'h00, 16'h0000, `PAGE_STATUS, 16'h0002, 8'h00, `OP_LOG_RD};
        bad[3] = {8'h00, 16'h0001, `PAGE_STATUS, 16'h0001, 8'h00, `OP_LOG_RD};
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        drive_state <= 8'(next_rand() % 6);
        status(1'b0);
        // Malformed forms leave the flag and the code alone
        for (k = 0; k < 4; k++) begin
            run_cmd(bad[k][31:0], bad[k][63:32], e);
            check("bad_form_err", e, 32'h1);
        end
        // Data page before any command
        run_cmd({16'h0001, 8'h00, `OP_LOG_RD}, {8'h00, 16'h0000, `PAGE_DATA}, e);
        check("early_data_err", e, 32'h1);
        exp_ext = `EXT_NO_CMD;
        status(1'b1);
        // Status while an action runs
        sct_busy <= 1'b1;
        drive_state <= 8'h05;
        exp_ext = 16'hffff;
        status(1'b0);
        sct_busy <= 1'b0;
        engine_done();
        // Key sector write starts an action
        key = next_rand();
        apb(1'b1, `BUF_BASE, key, q);
        run_cmd({16'h0001, 8'h00, `OP_LOG_WR}, {8'h00, 16'h0000, `PAGE_STATUS}, e);
        check("key_err", e, 32'h0);
        check("key_action", {got_fn, got_act}, key);
        exp_act = key[15:0];
        exp_fn = key[31:16];
        engine_done();
        drive_state <= 8'(next_rand() % 6);
        status(1'b1);
        // Data page both ways, log ext path
        run_cmd({16'h0001, 8'h00, `OP_LOG_WR}, {8'h00, 16'h0000, `PAGE_DATA}, e);
        check("data_wr_err", e, 32'h0);
        check("data_wr_bytes", wr_seen, 32'd512);
        run_cmd({16'h0008, 8'h00, `OP_LOG_RD}, {8'h00, 16'h0000, `PAGE_DATA}, e);
        check("data_rd_err", e, 32'h0);
        k = int'(next_rand() % 128);
        apb(1'b0, `BUF_BASE + 12'(4 * k), 32'h0, q);
        check("data_rd_word", q, {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)} ^ 32'h5a5a5a5a);
        // Flag set and cleared by drive events
        flag_step(3'b100, 1'b0);
        flag_step(3'b001, 1'b1);
        flag_step(3'b010, 1'b0);
        flag_step(3'b001, 1'b1);
        flag_step(3'b101, 1'b0);
        flag_step(3'b001, 1'b1);
        status(1'b0);
        // Power cycle restores the flag
        nv_seg_init <= seg_init;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        flag_step(3'b000, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
